// ---- hw/csat_pkg.sv ----
// constants and types shared by the core storage access timing block
// assumes a single 125 MHz clock and a synchronous active high reset
package csat_pkg;

    // clock and timing base
    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_PERIOD_NS = 2500;
    localparam int PULSE_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PULSES_PER_WORD = 8;
    localparam int PHASE_BITS = 3;
    localparam logic [2:0] PH_READ = 3'h2;
    localparam logic [2:0] PH_DELIVER = 3'h4;
    localparam logic [2:0] PH_WRITE = 3'h6;
    localparam logic [2:0] PH_LAST = 3'h7;

    // word and storage layout
    localparam int WORD_BITS = 20;
    localparam int STORE_BITS = 21;
    localparam int PAR_POS = 20;
    localparam int ADDR_BITS = 13;
    localparam int CORE_WORDS_MAX = 8192;
    localparam logic [12:0] MASK_4K = 13'h0fff;
    localparam logic [12:0] MASK_8K = 13'h1fff;

    // instruction fields
    localparam int OP_MSB = 19;
    localparam int OP_LSB = 15;
    localparam logic [4:0] OP_MUL = 5'h0c;
    localparam logic [4:0] OP_DIV = 5'h0d;
    localparam logic [4:0] OP_STORE = 5'h03;
    localparam int MULDIV_EXTRA_WORDS = 2;

    // drum block transfers
    localparam int TRACK_WORDS = 128;
    localparam int TRACK_SHIFT = 7;
    localparam logic [3:0] MAX_TRACKS = 4'h8;
    localparam int CNT_BITS = 11;

    // reset values
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [19:0] WORD_RESET = 20'h0_0000;

    // processor sequencing states
    typedef enum logic [2:0] {
        CPU_FETCH = 3'b001,
        CPU_EXEC = 3'b010,
        CPU_MULDIV = 3'b100
    } csat_cpu_e;

endpackage : csat_pkg

// ---- hw/csat_tick_if.sv ----
// timing base signals carried from the divider to the arbiter
// assumes both ends run on core_clk
`timescale 1ns/100ps
interface csat_tick_if;
    logic pulse_en;
    logic word_start;
    logic [2:0] phase;

    modport drive (output pulse_en, output word_start, output phase);
    modport use_tick (input pulse_en, input word_start, input phase);
endinterface : csat_tick_if

// ---- hw/csat_parity.sv ----
// xnor reduction: high when the input holds an even count of ones
// assumes nothing about its surroundings; purely combinational
`timescale 1ns/100ps
module csat_parity #(
    parameter int W = 20
) (
    input wire logic [W-1:0] data, // word to be counted
    output logic even            // high for an even count of ones
);
    // odd parity generator and checker share this reduction
    assign even = ~^data;
endmodule : csat_parity

// ---- hw/csat_timebase.sv ----
// basic pulse divider and eight pulse word time counter
// assumes core_clk at the rate fixed in the package
`timescale 1ns/100ps
module csat_timebase #(
    parameter int PULSE_CYCLES = csat_pkg::PULSE_CYCLES
) (
    input wire logic core_clk,   // system clock
    input wire logic srst,       // synchronous reset
    csat_tick_if.drive tick      // pulse, phase and word boundary
);
    logic [15:0] div_cnt;
    logic wrap;

    assign wrap = (div_cnt == 16'(PULSE_CYCLES - 1));

    // divider for the basic pulse train
    always_ff @(posedge core_clk)
    begin
        if (srst)
            div_cnt <= '0;
        else if (wrap)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    // one pulse enable and the pulse index within the word
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tick.pulse_en <= 1'b0;
            tick.word_start <= 1'b0;
            tick.phase <= csat_pkg::PH_LAST;
        end
        else
        begin
            tick.pulse_en <= wrap;
            tick.word_start <= wrap && (tick.phase == csat_pkg::PH_LAST);
            if (wrap)
                tick.phase <= tick.phase + 3'h1;
        end
    end
endmodule : csat_timebase

// ---- hw/csat_arbiter.sv ----
// core storage with word time sequencing, processor sequencer,
// drum block transfer engine and fixed priority access arbiter
// assumes io requesters on core_clk; drum pins are asynchronous
//
// How it works
// - divider makes 2.5 us basic pulse train
// - eight pulses form one 20 us word time
// - read, deliver, rewrite within each word time
// - one word fetch, one word execute
// - multiply and divide take extra word times
// - fetch next instruction only after completion
// - 20-bit word plus generated check bit stored
// - check bit recomputed on every read out
// - core capacity selectable 4096 or 8192 words
// - drum tracks hold 128 core format words
// - drum block moves one to eight tracks
// - drum gains core access without processor help
// - drum and processor share core by word times
// - transfer complete flag when block finishes
// - processor suspended while io devices use core
// - at most one grant per word time
// - higher repetition rate requester wins ties
// - losing requester holds, competes again next word time
// - processor always ranks lowest
// - odd parity; even count on read errors
`timescale 1ns/100ps
module csat_arbiter #(
    parameter int N_IO = 2,
    parameter int CORE_WORDS = csat_pkg::CORE_WORDS_MAX,
    parameter int PULSE_CYCLES = csat_pkg::PULSE_CYCLES
) (
    input wire logic core_clk,                  // 125 MHz clock
    input wire logic srst,                      // synchronous reset
    input wire logic cap_8k,                    // capacity pin, 1 = 8192
    input wire logic cpu_run,                   // processor may run
    input wire logic [19:0] cpu_store_data,     // data for store op
    input wire logic [N_IO-1:0] io_req,         // io access requests
    input wire logic [N_IO-1:0] io_we,          // io write, 0 = read
    input wire logic [N_IO*13-1:0] io_addr,     // io addresses
    input wire logic [N_IO*20-1:0] io_wdata,    // io write data
    input wire logic drum_cmd_start,            // start block pulse
    input wire logic drum_cmd_to_core,          // 1 = drum into core
    input wire logic [12:0] drum_cmd_addr,      // first core address
    input wire logic [3:0] drum_cmd_tracks,     // tracks, 1 to 8
    input wire logic drum_word_strobe,          // drum word slot pin
    input wire logic [19:0] drum_rdata,         // drum word pins
    input wire logic drum_done_clr,             // clear done flag
    input wire logic parity_clr,                // clear parity flag
    output logic [N_IO-1:0] io_grant,           // held for the word
    output logic [19:0] rd_data,                // word read from core
    output logic rd_valid,                      // rd_data pulse
    output logic par_err_pulse,                 // bad read this word
    output logic parity_error,                  // sticky parity flag
    output logic [12:0] cpu_pc,                 // next instruction
    output logic [19:0] cpu_ir,                 // current instruction
    output logic [19:0] cpu_operand,            // last operand read
    output logic drum_busy,                     // block in progress
    output logic drum_done,                     // transfer complete
    output logic [19:0] drum_wdata,             // word to drum
    output logic drum_wvalid                    // drum_wdata pulse
);
    localparam int NREQ = N_IO + 2;
    localparam int CPU_IDX = NREQ - 1;
    localparam int AW = csat_pkg::ADDR_BITS;
    localparam int W = csat_pkg::WORD_BITS;

    csat_tick_if tk ();

    logic [NREQ-1:0] grant;
    logic [NREQ-1:0] next_grant;
    logic [NREQ-1:0] req_vec;
    logic [AW-1:0] cur_addr;
    logic [AW-1:0] next_addr;
    logic cur_we;
    logic next_we;
    logic [W-1:0] cur_wdata;
    logic [W-1:0] next_wdata;
    logic [csat_pkg::STORE_BITS-1:0] z_word;
    logic [csat_pkg::STORE_BITS-1:0] core_mem [0:CORE_WORDS-1];
    logic gen_even;
    logic chk_even;
    logic [AW-1:0] addr_mask;
    csat_pkg::csat_cpu_e cpu_state;
    csat_pkg::csat_cpu_e next_cpu_state;
    logic [1:0] muldiv_cnt;
    logic cpu_need;
    logic [4:0] ir_op;
    logic [2:0] cap_sync;
    logic cap_lvl;
    logic [2:0] strb_sync;
    logic strb_lvl;
    logic strb_prev;
    logic strb_edge;
    logic [W-1:0] drum_word;
    logic drum_pend;
    logic drum_to_core;
    logic [AW-1:0] drum_addr;
    logic [csat_pkg::CNT_BITS-1:0] drum_left;
    logic at_read;
    logic at_deliver;
    logic at_write;
    logic drum_last;

    // basic pulse and word time counter
    csat_timebase #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_timebase (
        .core_clk(core_clk),
        .srst(srst),
        .tick(tk.drive)
    );

    assign at_read = tk.pulse_en && (tk.phase == csat_pkg::PH_READ);
    assign at_deliver = tk.pulse_en && (tk.phase == csat_pkg::PH_DELIVER);
    assign at_write = tk.pulse_en && (tk.phase == csat_pkg::PH_WRITE);

    // check bit generation on store and check on read out
    csat_parity #(.W(W)) u_par_gen (
        .data(cur_wdata),
        .even(gen_even)
    );
    csat_parity #(.W(csat_pkg::STORE_BITS)) u_par_chk (
        .data(z_word),
        .even(chk_even)
    );

    // capacity pin: three stage sync, change taken when stages agree
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cap_sync <= 3'h7; // matches the 8K level, no false change
            cap_lvl <= 1'b1;
        end
        else
        begin
            cap_sync <= {cap_sync[1:0], cap_8k};
            if (cap_sync[1] == cap_sync[2])
                cap_lvl <= cap_sync[2];
        end
    end
    assign addr_mask = cap_lvl ? csat_pkg::MASK_8K : csat_pkg::MASK_4K;

    // drum strobe pin: three stage sync and rising edge
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            strb_sync <= 3'h0;
            strb_lvl <= 1'b0;
            strb_prev <= 1'b0;
        end
        else
        begin
            strb_sync <= {strb_sync[1:0], drum_word_strobe};
            if (strb_sync[1] == strb_sync[2])
                strb_lvl <= strb_sync[2];
            strb_prev <= strb_lvl;
        end
    end
    assign strb_edge = strb_lvl && !strb_prev;
    assign drum_last = (drum_left == 11'h001);

    // drum block engine: accept command, count words, flag completion
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            drum_busy <= 1'b0;
            drum_to_core <= 1'b0;
            drum_addr <= '0;
            drum_left <= '0;
        end
        else if (!drum_busy && drum_cmd_start &&
                 drum_cmd_tracks != 4'h0 &&
                 drum_cmd_tracks <= csat_pkg::MAX_TRACKS)
        begin
            drum_busy <= 1'b1;
            drum_to_core <= drum_cmd_to_core;
            drum_addr <= drum_cmd_addr & addr_mask;
            drum_left <= 11'(drum_cmd_tracks) <<
                         csat_pkg::TRACK_SHIFT;
        end
        else if (drum_busy && at_deliver && grant[0])
        begin
            drum_addr <= (drum_addr + 13'h0001) & addr_mask;
            drum_left <= drum_left - 11'h001;
            if (drum_last)
                drum_busy <= 1'b0;
        end
    end

    // completion flag; a new completion wins over a clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
            drum_done <= 1'b0;
        else if (drum_busy && at_deliver && grant[0] && drum_last)
            drum_done <= 1'b1;
        else if (drum_done_clr)
            drum_done <= 1'b0;
    end

    // drum word slot raises a pending request on its own
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            drum_pend <= 1'b0;
            drum_word <= csat_pkg::WORD_RESET;
        end
        else if (drum_busy && strb_edge)
        begin
            drum_pend <= 1'b1;
            drum_word <= drum_rdata;
        end
        else if (tk.word_start && next_grant[0])
            drum_pend <= 1'b0;
    end

    // processor sequencing decided at each word boundary
    assign ir_op = cpu_ir[csat_pkg::OP_MSB:csat_pkg::OP_LSB];
    always_comb
    begin
        next_cpu_state = cpu_state;
        case (cpu_state)
            csat_pkg::CPU_FETCH:
                if (grant[CPU_IDX])
                    next_cpu_state = csat_pkg::CPU_EXEC;
            csat_pkg::CPU_EXEC:
                if (grant[CPU_IDX])
                begin
                    if (ir_op == csat_pkg::OP_MUL ||
                        ir_op == csat_pkg::OP_DIV)
                        next_cpu_state = csat_pkg::CPU_MULDIV;
                    else
                        next_cpu_state = csat_pkg::CPU_FETCH;
                end
            csat_pkg::CPU_MULDIV:
                if (muldiv_cnt == 2'h0)
                    next_cpu_state = csat_pkg::CPU_FETCH;
            default:
                next_cpu_state = csat_pkg::CPU_FETCH;
        endcase
    end
    assign cpu_need = cpu_run && (next_cpu_state != csat_pkg::CPU_MULDIV);

    // processor state and multiply or divide word counter
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cpu_state <= csat_pkg::CPU_FETCH;
            muldiv_cnt <= 2'h0;
        end
        else if (tk.word_start)
        begin
            cpu_state <= next_cpu_state;
            if (cpu_state == csat_pkg::CPU_EXEC)
                muldiv_cnt <= 2'(csat_pkg::MULDIV_EXTRA_WORDS - 1);
            else if (muldiv_cnt != 2'h0)
                muldiv_cnt <= muldiv_cnt - 2'h1;
        end
    end

    // requests ordered by repetition rate, drum first, processor last
    assign req_vec = {cpu_need, io_req, drum_pend};

    // fixed priority pick and the chosen requester's access
    always_comb
    begin
        logic found;
        found = 1'b0;
        next_grant = '0;
        next_addr = '0;
        next_we = 1'b0;
        next_wdata = csat_pkg::WORD_RESET;
        for (int i = 0; i < NREQ; i++)
        begin
            if (req_vec[i] && !found)
            begin
                found = 1'b1;
                next_grant[i] = 1'b1;
                if (i == 0)
                begin
                    next_addr = drum_addr;
                    next_we = drum_to_core;
                    next_wdata = drum_word;
                end
                else if (i == CPU_IDX)
                begin
                    if (next_cpu_state == csat_pkg::CPU_FETCH)
                        next_addr = cpu_pc;
                    else
                    begin
                        next_addr = cpu_ir[AW-1:0];
                        next_we = (ir_op == csat_pkg::OP_STORE);
                        next_wdata = cpu_store_data;
                    end
                end
                else
                begin
                    next_addr = io_addr[(i-1)*AW +: AW];
                    next_we = io_we[i-1];
                    next_wdata = io_wdata[(i-1)*W +: W];
                end
            end
        end
    end

    // grant latched at the boundary and held for the word time;
    // losers keep requesting and compete again in the next word's pick
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            grant <= '0;
            cur_addr <= '0;
            cur_we <= 1'b0;
            cur_wdata <= csat_pkg::WORD_RESET;
        end
        else if (tk.word_start)
        begin
            grant <= next_grant;
            cur_addr <= next_addr & addr_mask;
            cur_we <= next_we;
            cur_wdata <= next_wdata;
        end
    end
    assign io_grant = grant[N_IO:1];

    // destructive read into the word register, then rewrite
    always_ff @(posedge core_clk)
    begin
        if (srst)
            z_word <= '0;
        else if (at_read && (|grant))
            z_word <= core_mem[cur_addr];
    end

    always_ff @(posedge core_clk)
    begin
        if (!srst && at_write && (|grant))
        begin
            if (cur_we)
                core_mem[cur_addr] <= {gen_even, cur_wdata};
            else
                core_mem[cur_addr] <= z_word;
        end
    end

    // deliver the read word and its check result
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rd_data <= csat_pkg::WORD_RESET;
            rd_valid <= 1'b0;
            par_err_pulse <= 1'b0;
            drum_wdata <= csat_pkg::WORD_RESET;
            drum_wvalid <= 1'b0;
        end
        else
        begin
            rd_valid <= at_deliver && (|grant) && !cur_we;
            par_err_pulse <= at_deliver && (|grant) && !cur_we &&
                             chk_even;
            drum_wvalid <= at_deliver && grant[0] && !cur_we;
            if (at_deliver && (|grant) && !cur_we)
                rd_data <= z_word[W-1:0];
            if (at_deliver && grant[0] && !cur_we)
                drum_wdata <= z_word[W-1:0];
        end
    end

    // sticky parity flag; a new error wins over a clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
            parity_error <= 1'b0;
        else if (at_deliver && (|grant) && !cur_we && chk_even)
            parity_error <= 1'b1;
        else if (parity_clr)
            parity_error <= 1'b0;
    end

    // instruction register, counter and operand capture
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cpu_pc <= csat_pkg::PC_RESET;
            cpu_ir <= csat_pkg::WORD_RESET;
            cpu_operand <= csat_pkg::WORD_RESET;
        end
        else if (at_deliver && grant[CPU_IDX])
        begin
            if (cpu_state == csat_pkg::CPU_FETCH)
            begin
                cpu_ir <= z_word[W-1:0];
                cpu_pc <= (cpu_pc + 13'h0001) & addr_mask;
            end
            else if (!cur_we)
                cpu_operand <= z_word[W-1:0];
        end
    end
endmodule : csat_arbiter

// ---- testbench/csat_checker.sv ----
// concurrent checks on the arbiter top ports
// assumes it is bound onto csat_arbiter
`timescale 1ns/100ps
module csat_checker #(
    parameter int N_IO = 2,
    parameter int PULSE_CYCLES = 312
) (
    input wire logic core_clk, // clock
    input wire logic srst, // sync reset
    input wire logic [N_IO-1:0] io_req, // io requests
    input wire logic [N_IO-1:0] io_we, // io write flags
    input wire logic [N_IO-1:0] io_grant, // io grants
    input wire logic rd_valid, // read pulse
    input wire logic par_err_pulse, // bad read pulse
    input wire logic parity_error, // sticky parity flag
    input wire logic drum_busy, // block in progress
    input wire logic drum_done, // block finished
    input wire logic drum_wvalid // word to drum pulse
);
    localparam int RD_LAT = 4 * PULSE_CYCLES;
    localparam int WORD = 8 * PULSE_CYCLES;
    int run;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // cycles the port 0 grant has stood so far
    always_ff @(posedge core_clk)
    begin
        if (srst || !io_grant[0])
            run <= 0;
        else
            run <= run + 1;
    end
    sequence s_rd_grant;
        $rose(io_grant[0]) && !io_we[0];
    endsequence
    sequence s_answer;
        ##[RD_LAT:RD_LAT] rd_valid;
    endsequence
    AST_ONE_GRANT: assert property ($onehot0(io_grant))
        else $error("two grants in one word");
    AST_TIE_ORDER: assert property ($rose(io_grant[1]) |-> !$past(io_req[0]))
        else $error("port 1 granted over port 0");
    AST_READ_TIME: assert property (s_rd_grant |-> s_answer)
        else $error("read word late or missing");
    AST_WORD_HOLD: assert property ($fell(io_grant[0]) |-> run % WORD == 0)
        else $error("grant not held whole word times");
    AST_RD_PULSE: assert property (rd_valid |=> !rd_valid)
        else $error("read pulse too long");
    AST_PAR_WITH_RD: assert property (par_err_pulse |-> rd_valid)
        else $error("parity pulse without read");
    AST_PAR_STICKY: assert property (par_err_pulse |=> parity_error)
        else $error("parity flag not set");
    AST_DONE_AT_END: assert property ($fell(drum_busy) |-> drum_done)
        else $error("block ended without done");
    AST_DRUM_PULSE: assert property (drum_wvalid |=> !drum_wvalid)
        else $error("drum word pulse too long");
endmodule : csat_checker

bind csat_arbiter csat_checker #(.N_IO(N_IO), .PULSE_CYCLES(PULSE_CYCLES))
    u_chk (.core_clk(core_clk), .srst(srst), .io_req(io_req), .io_we(io_we),
    .io_grant(io_grant), .rd_valid(rd_valid), .par_err_pulse(par_err_pulse),
    .parity_error(parity_error), .drum_busy(drum_busy),
    .drum_done(drum_done), .drum_wvalid(drum_wvalid));

// ---- testbench/csat_drum_model.sv ----
// drum side model: one word slot every 63 clocks while go is high
// assumes the bench knows word n carries base xor n
`timescale 1ns/100ps
module csat_drum_model #(
    parameter logic [19:0] BASE = 20'h5_a000
) (
    input wire logic core_clk, // clock
    input wire logic go, // send word slots
    output logic strobe, // word slot pin
    output logic [19:0] rdata // word pins
);
    int n;
    // data settles before the strobe edge and is held well after it
    initial
    begin
        strobe = 1'b0;
        rdata = 20'h0_0000;
        n = 0;
        forever
        begin
            @(posedge core_clk);
            if (go)
            begin
                rdata <= BASE ^ 20'(n);
                repeat (4) @(posedge core_clk);
                strobe <= 1'b1;
                repeat (20) @(posedge core_clk);
                strobe <= 1'b0;
                rdata <= ~rdata; // released lines lose the word
                n++;
                repeat (38) @(posedge core_clk);
            end
        end
    end
endmodule : csat_drum_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the core access arbiter
// assumes short pulse spacing of 4 clocks, so a word is 32 clocks
`timescale 1ns/100ps
module tb_top;
    localparam logic [19:0] BASE = 20'h5_a000;
    logic core_clk, srst, cap_8k, cpu_run, go, mon_on;
    logic [19:0] cpu_store_data, rd_data, drum_rdata, drum_wdata;
    logic [19:0] cpu_ir, cpu_operand;
    logic [1:0] io_req, io_we, io_grant;
    logic [25:0] io_addr;
    logic [39:0] io_wdata;
    logic drum_cmd_start, drum_cmd_to_core, drum_word_strobe;
    logic drum_done_clr, parity_clr, rd_valid, par_err_pulse, parity_error;
    logic drum_busy, drum_done, drum_wvalid;
    logic [12:0] drum_cmd_addr, cpu_pc, mask;
    logic [3:0] drum_cmd_tracks;
    logic [19:0] mem_m [logic [12:0]];
    logic [19:0] rq[$], dq[$];
    int n_errors, num_checks, first_p;

    csat_arbiter #(.PULSE_CYCLES(4)) dut (.core_clk(core_clk), .srst(srst),
        .cap_8k(cap_8k), .cpu_run(cpu_run), .cpu_store_data(cpu_store_data),
        .io_req(io_req), .io_we(io_we), .io_addr(io_addr),
        .io_wdata(io_wdata), .drum_cmd_start(drum_cmd_start),
        .drum_cmd_to_core(drum_cmd_to_core), .drum_cmd_addr(drum_cmd_addr),
        .drum_cmd_tracks(drum_cmd_tracks),
        .drum_word_strobe(drum_word_strobe), .drum_rdata(drum_rdata),
        .drum_done_clr(drum_done_clr), .parity_clr(parity_clr),
        .io_grant(io_grant), .rd_data(rd_data), .rd_valid(rd_valid),
        .par_err_pulse(par_err_pulse), .parity_error(parity_error),
        .cpu_pc(cpu_pc), .cpu_ir(cpu_ir), .cpu_operand(cpu_operand),
        .drum_busy(drum_busy), .drum_done(drum_done),
        .drum_wdata(drum_wdata), .drum_wvalid(drum_wvalid));
    csat_drum_model #(.BASE(BASE)) u_drum (.core_clk(core_clk), .go(go),
        .strobe(drum_word_strobe), .rdata(drum_rdata));

    // 8 ns clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic cmp20(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp20

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // one io word access; request held until the grant is seen
    task automatic io_acc(input int p, input logic we, input logic [12:0] a,
                          input logic [19:0] d);
        int k;
        tick(1);
        io_we[p] = we;
        io_addr[p*13 +: 13] = a;
        io_wdata[p*20 +: 20] = d;
        io_req[p] = 1'b1;
        k = 0;
        while (io_grant[p] !== 1'b1 && k < 400)
        begin
            tick(1);
            k++;
        end
        cmp20("io_grant", 20'h0_0001, 20'(io_grant[p]));
        if (first_p < 0)
            first_p = p;
        if (we)
            mem_m[a & mask] = d;
        else
            rq.push_back(mem_m[a & mask]);
        io_req[p] = 1'b0;
    endtask : io_acc

    task automatic drum_run(input logic to_core);
        int k;
        drum_cmd_to_core = to_core;
        drum_cmd_addr = 13'h0200;
        drum_cmd_tracks = 4'h1;
        drum_cmd_start = 1'b1;
        tick(1);
        drum_cmd_start = 1'b0;
        cmp20("busy", 20'h0_0001, 20'(drum_busy));
        go = 1'b1;
        k = 0;
        while (drum_busy === 1'b1 && k < 10000)
        begin
            tick(1);
            k++;
        end
        go = 1'b0;
        cmp20("done", 20'h0_0001, 20'(drum_done));
        drum_done_clr = 1'b1;
        tick(1);
        drum_done_clr = 1'b0;
        tick(1);
        cmp20("done clr", 20'h0_0000, 20'(drum_done));
    endtask : drum_run

    // results are checked against the oldest note as they appear
    always @(posedge core_clk)
    begin
        if (mon_on && rd_valid === 1'b1)
        begin
            cmp20("rd_data", rq.pop_front(), rd_data);
            cmp20("par_err", 20'h0_0000, 20'(par_err_pulse));
        end
        if (drum_wvalid === 1'b1)
            cmp20("drum_wdata", dq.pop_front(), drum_wdata);
    end

    // cut a hang short
    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("BAD watchdog expected end seen hang");
        complete_run();
    end

    // main sequence
    initial
    begin
        srst = 1'b1;
        {cpu_run, go, io_req, io_we, io_addr, io_wdata, drum_cmd_tracks} = '0;
        {drum_cmd_start, drum_cmd_to_core, drum_cmd_addr, drum_done_clr} = '0;
        cap_8k = 1'b1;
        {parity_clr, mon_on} = 2'b11;
        mask = 13'h1fff;
        {n_errors, num_checks} = '0;
        first_p = -1;
        void'($urandom(32'h2f987d07));
        cpu_store_data = 20'($urandom);
        tick(16);
        srst = 1'b0;
        tick(2);
        parity_clr = 1'b0;
        for (int i = 0; i < 4; i++)
            io_acc(i % 2, 1'b1, 13'h1000 + 13'(i), 20'($urandom));
        for (int i = 0; i < 4; i++)
            io_acc(i % 2, 1'b0, 13'h1000 + 13'(i), 20'h0_0000);
        tick(40);
        first_p = -1;
        fork
            io_acc(1, 1'b0, 13'h1001, 20'h0_0000);
            io_acc(0, 1'b0, 13'h1002, 20'h0_0000);
        join
        cmp20("first grant", 20'h0_0000, 20'(first_p));
        tick(80);
        $display("test access and priority done");
        cap_8k = 1'b0;
        tick(10);
        mask = 13'h0fff;
        io_acc(0, 1'b1, 13'h1005, 20'($urandom));
        io_acc(1, 1'b0, 13'h0005, 20'h0_0000);
        tick(40);
        cap_8k = 1'b1;
        mask = 13'h1fff;
        tick(10);
        $display("test capacity done");
        for (int t = 0; t < 10; t += 9)
        begin
            drum_cmd_tracks = 4'(t);
            drum_cmd_start = 1'b1;
            tick(1);
            drum_cmd_start = 1'b0;
            tick(2);
            cmp20("busy bad tracks", 20'h0_0000, 20'(drum_busy));
        end
        drum_run(1'b1);
        for (int i = 0; i < 128; i++)
            mem_m[13'h0200 + 13'(i)] = BASE ^ 20'(i);
        io_acc(0, 1'b0, 13'h0200, 20'h0_0000);
        io_acc(1, 1'b0, 13'h027f, 20'h0_0000);
        tick(40);
        for (int i = 0; i < 128; i++)
        begin
            dq.push_back(BASE ^ 20'(i));
            rq.push_back(BASE ^ 20'(i)); // drum reads show on rd_data too
        end
        drum_run(1'b0);
        cmp20("drum words left", 20'h0_0000, 20'(dq.size()));
        $display("test drum blocks done");
        io_acc(0, 1'b1, 13'h0000, {5'h01, 2'b00, 13'h1000});
        tick(40);
        mon_on = 1'b0;
        cpu_run = 1'b1;
        for (int w = 0; w < 2; w++)
        begin
            while (rd_valid !== 1'b1)
                @(posedge core_clk);
            tick(2);
        end
        cmp20("cpu_ir", mem_m[13'h0000], cpu_ir);
        cmp20("cpu_pc", 20'h0_0001, 20'(cpu_pc));
        cmp20("cpu_operand", mem_m[13'h1000], cpu_operand);
        cpu_run = 1'b0;
        $display("test processor done");
        cmp20("reads left", 20'h0_0000, 20'(rq.size()));
        complete_run();
    end
endmodule : tb_top
